/* File: rtl/hub_ctl_pkg.sv */
package hub_ctl_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;

  // Register offsets
  localparam logic [7:0] ADDR_IND_CTL   = 8'hb0;
  localparam logic [7:0] ADDR_IND_OFS   = 8'hb1;
  localparam logic [7:0] ADDR_IND_DATA  = 8'hb2;
  localparam logic [7:0] ADDR_SELFTEST  = 8'hb3;
  localparam logic [7:0] ADDR_STRAP_STS = 8'hb8;
  localparam logic [7:0] ADDR_LINK_ERR  = 8'hb9;
  localparam logic [7:0] ADDR_FV_MIN    = 8'hbc;
  localparam logic [7:0] ADDR_GPIO_PD   = 8'hbe;

  // Field positions
  localparam int unsigned IND_SEL_LSB     = 2;
  localparam int unsigned IND_AUTO_BIT    = 1;
  localparam int unsigned IND_READ_BIT    = 0;
  localparam int unsigned ST_MODE_LSB     = 6;
  localparam int unsigned ST_CFG_PIN_BIT  = 3;
  localparam int unsigned ST_CLK_LSB      = 1;
  localparam int unsigned ST_EN_BIT       = 0;
  localparam int unsigned LE_WAIT_BIT     = 5;
  localparam int unsigned LE_EN_BIT       = 4;

  // Reset values
  localparam logic [7:0] SELFTEST_RST = 8'h08;
  localparam logic [3:0] LE_THRESH_RST = 4'h3;
  localparam logic [7:0] FV_MIN_RST   = 8'h80;

  // Indirect targets and remote serializer location
  localparam logic [3:0] TGT_PATGEN    = 4'h0;
  localparam logic [3:0] TGT_PORT_LAST = 4'h4;
  localparam logic [7:0] REMOTE_CLKSRC_OFS = 8'h14;

  // Timing
  localparam int unsigned STRAP_SETTLE_NS  = 1000;
  localparam int unsigned STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FILTER_WAIT_NS   = 500;
  localparam int unsigned FILTER_WAIT_CYC  = (FILTER_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] sel;
    logic [7:0] offset;
    logic [7:0] wr_offset;
    logic [7:0] wdata;
  } ind_req_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } remote_wr_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOAD = 3'b010,
    ST_RUN  = 3'b100
  } selftest_state_t;

  function automatic logic ind_target_valid(input logic [3:0] sel);
    return (sel >= TGT_PATGEN) && (sel <= TGT_PORT_LAST);
  endfunction

endpackage

/* File: rtl/strap_latch.sv */
`timescale 1ns/1ps
module strap_latch
  import hub_ctl_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic [2:0] strap_i,
  output logic      [2:0] value_o,
  output logic            done_o
);

  logic [2:0] s1_ff;
  logic [2:0] s2_ff;
  logic [7:0] cnt_ff;

  always_ff @(posedge sys_clk_i)
  begin
    s1_ff <= strap_i;
    s2_ff <= s1_ff;
  end

  // Strap is caught after the pin settles, then frozen
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      cnt_ff  <= 8'h00;
      value_o <= 3'h0;
      done_o  <= 1'b0;
    end
    else if (!done_o)
    begin
      if (cnt_ff == 8'(STRAP_SETTLE_CYC - 1))
      begin
        value_o <= s2_ff;
        done_o  <= 1'b1;
      end
      else
        cnt_ff <= cnt_ff + 8'h01;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  property p_done_freezes;
    done_o |=> done_o && $stable(value_o);
  endproperty
  a_done_freezes: assert property (p_done_freezes) else $error("strap value moved after latch");

endmodule // strap_latch

/* File: rtl/link_err_counter.sv */
`timescale 1ns/1ps
module link_err_counter
  import hub_ctl_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic [3:0] err_i,
  input  wire logic       filter_update_i,
  input  wire logic       relock_i,
  input  wire logic       count_en_i,
  input  wire logic       wait_ignore_i,
  input  wire logic [3:0] threshold_i,
  output logic            locked_o
);

  logic [5:0] s1_ff;
  logic [5:0] s2_ff;
  logic       fupd_d_ff;
  logic [7:0] wait_ff;
  logic [3:0] cnt_ff;
  logic       err_seen;

  always_ff @(posedge sys_clk_i)
  begin
    s1_ff <= {relock_i, filter_update_i, err_i};
    s2_ff <= s1_ff;
    fupd_d_ff <= s2_ff[4];
  end

  // Wait window opened by each filter update
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      wait_ff <= 8'h00;
    else if (s2_ff[4] && !fupd_d_ff)
      wait_ff <= 8'(FILTER_WAIT_CYC);
    else if (wait_ff != 8'h00)
      wait_ff <= wait_ff - 8'h01;
  end

  assign err_seen = (|s2_ff[3:0]) && !(wait_ignore_i && (wait_ff != 8'h00));

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      locked_o <= 1'b0;
      cnt_ff   <= 4'h0;
    end
    else if (!locked_o)
    begin
      locked_o <= s2_ff[5];
      cnt_ff   <= 4'h0;
    end
    else if (err_seen)
    begin
      if (!count_en_i)
        locked_o <= 1'b0;
      else if ({1'b0, cnt_ff} + 5'h01 >= {1'b0, threshold_i})
        locked_o <= 1'b0;
      else
        cnt_ff <= cnt_ff + 4'h1;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  property p_drop_first;
    locked_o && err_seen && !count_en_i |=> !locked_o;
  endproperty
  a_drop_first: assert property (p_drop_first) else $error("lock kept after error with counting off");

  property p_drop_thresh;
    locked_o && err_seen && count_en_i && ({1'b0, cnt_ff} + 5'h01 >= {1'b0, threshold_i}) |=> !locked_o;
  endproperty
  a_drop_thresh: assert property (p_drop_thresh) else $error("lock kept at threshold");

  property p_ignore_wait;
    locked_o && wait_ignore_i && (wait_ff > 8'h01) |=> locked_o;
  endproperty
  a_ignore_wait: assert property (p_ignore_wait) else $error("lock lost inside filter wait");

endmodule // link_err_counter

/* File: rtl/hub_shared_ctl.sv */
`timescale 1ns/1ps
// Operation
// - Four-bit select routes indirect accesses
// - Auto-increment advances offset after each access
// - Offset write issues read strobe when enabled
// - Data read prefetches next location too
// - Offset register holds eight-bit target offset
// - Data write writes selected block location
// - Data read returns selected block content
// - Output mode picks none, alternate, data
// - Config source bit picks pin or register
// - Enable pushes clock source to remote
// - Index strap latched and done set on the same clock edge
// - Mode strap latched and done set on the same clock edge
// - Filter wait can mask lock errors
// - Counting on: drop lock at threshold
// - Counting off: drop lock first error
// - Count clock, parity, balance bit errors
// - Pull-down disable versus automatic pull-down
// - Access control upper bits read zero
module hub_shared_ctl
  import hub_ctl_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  output ind_req_t        ind_req_o,
  input  wire logic [7:0] ind_rdata_i,
  input  wire logic       selftest_pin_i,
  input  wire logic       selftest_data_i,
  output logic            selftest_active_o,
  output logic            test_out_o,
  output remote_wr_t      remote_o,
  input  wire logic [2:0] idx_strap_i,
  input  wire logic [2:0] mode_strap_i,
  input  wire logic [3:0] link_err_i,
  input  wire logic       filter_update_i,
  input  wire logic       relock_i,
  output logic            rx_lock_o,
  input  wire logic       raw_mode_i,
  input  wire logic       frame_valid_i,
  output logic            frame_start_o,
  input  wire logic [7:0] gpio_oe_i,
  output logic      [7:0] gpio_pd_en_o
);

  logic            auto_inc_ff;
  logic            read_pf_ff;
  logic [7:0]      selftest_ff;
  logic [7:0]      link_ctl_ff;
  logic [7:0]      fv_min_ff;
  logic [7:0]      pd_dis_ff;
  logic [2:0]      pin_s1_ff;
  logic [2:0]      pin_s2_ff;
  logic [7:0]      fv_cnt_ff;
  logic            fs_done_ff;
  selftest_state_t state_ff;
  selftest_state_t nxt_state;
  logic            st_enable;
  logic [2:0]      idx_val;
  logic            index_decode_done;
  logic [2:0]      mode_val;
  logic            mode_done;
  logic            wr_ctl;
  logic            wr_ofs;
  logic            wr_data;
  logic            rd_data;
  logic            sel_ok;

  function automatic logic hit(input logic strobe, input logic [7:0] addr, input logic [7:0] ofs);
    return strobe && (addr == ofs);
  endfunction

  assign wr_ctl  = hit(reg_wr_i, reg_addr_i, ADDR_IND_CTL);
  assign wr_ofs  = hit(reg_wr_i, reg_addr_i, ADDR_IND_OFS);
  assign wr_data = hit(reg_wr_i, reg_addr_i, ADDR_IND_DATA);
  assign rd_data = hit(reg_rd_i, reg_addr_i, ADDR_IND_DATA);
  assign sel_ok  = ind_target_valid(ind_req_o.sel);

  // Pins from the remote side: bist pin, bist data, frame valid
  always_ff @(posedge sys_clk_i)
  begin
    pin_s1_ff <= {frame_valid_i, selftest_data_i, selftest_pin_i};
    pin_s2_ff <= pin_s1_ff;
  end

  // Indirect access control and strobes
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      ind_req_o   <= '0;
      auto_inc_ff <= 1'b0;
      read_pf_ff  <= 1'b0;
    end
    else
    begin
      ind_req_o.wr <= 1'b0;
      ind_req_o.rd <= 1'b0;
      if (wr_ctl)
      begin
        ind_req_o.sel <= reg_wdata_i[IND_SEL_LSB +: 4];
        auto_inc_ff   <= reg_wdata_i[IND_AUTO_BIT];
        read_pf_ff    <= reg_wdata_i[IND_READ_BIT];
      end
      if (wr_ofs)
      begin
        ind_req_o.offset <= reg_wdata_i;
        ind_req_o.rd     <= read_pf_ff && sel_ok;
      end
      if (wr_data)
      begin
        ind_req_o.wdata     <= reg_wdata_i;
        ind_req_o.wr_offset <= ind_req_o.offset;
        ind_req_o.wr        <= sel_ok;
        if (auto_inc_ff)
          ind_req_o.offset <= ind_req_o.offset + 8'h01;
      end
      if (rd_data && auto_inc_ff)
      begin
        ind_req_o.offset <= ind_req_o.offset + 8'h01;
        ind_req_o.rd     <= read_pf_ff && sel_ok;
      end
    end
  end

  // Plain control registers
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      selftest_ff <= SELFTEST_RST;
      link_ctl_ff <= {4'h0, LE_THRESH_RST};
      fv_min_ff   <= FV_MIN_RST;
      pd_dis_ff   <= 8'h00;
    end
    else if (reg_wr_i)
    begin
      unique case (reg_addr_i)
        ADDR_SELFTEST: selftest_ff <= reg_wdata_i;
        ADDR_LINK_ERR: link_ctl_ff <= {2'b00, reg_wdata_i[5:0]};
        ADDR_FV_MIN:   fv_min_ff   <= reg_wdata_i;
        ADDR_GPIO_PD:  pd_dis_ff   <= reg_wdata_i;
        default:       ;
      endcase
    end
  end

  // Read data stands one cycle after the strobe only
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        ADDR_IND_CTL:   reg_rdata_o <= {2'b00, ind_req_o.sel, auto_inc_ff, read_pf_ff};
        ADDR_IND_OFS:   reg_rdata_o <= ind_req_o.offset;
        ADDR_IND_DATA:  reg_rdata_o <= sel_ok ? ind_rdata_i : 8'h00;
        ADDR_SELFTEST:  reg_rdata_o <= selftest_ff;
        ADDR_STRAP_STS: reg_rdata_o <= {index_decode_done, idx_val, mode_done, mode_val};
        ADDR_LINK_ERR:  reg_rdata_o <= link_ctl_ff;
        ADDR_FV_MIN:    reg_rdata_o <= fv_min_ff;
        ADDR_GPIO_PD:   reg_rdata_o <= pd_dis_ff;
        default:        reg_rdata_o <= 8'h00;
      endcase
    end
    else
      reg_rdata_o <= 8'h00;
  end

  // Self-test enable comes from the pin or from the register
  assign st_enable = selftest_ff[ST_CFG_PIN_BIT] ? pin_s2_ff[0] : selftest_ff[ST_EN_BIT];

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: if (st_enable) nxt_state = ST_LOAD;
      ST_LOAD: nxt_state = ST_RUN;
      ST_RUN:  if (!st_enable) nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // Clock source is pushed to the remote once per enable
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      remote_o <= '0;
    else
    begin
      remote_o.wr   <= (state_ff == ST_LOAD);
      remote_o.addr <= REMOTE_CLKSRC_OFS;
      remote_o.data <= {6'h00, selftest_ff[ST_CLK_LSB +: 2]};
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      selftest_active_o <= 1'b0;
      test_out_o        <= 1'b0;
    end
    else
    begin
      selftest_active_o <= (nxt_state == ST_RUN);
      if (state_ff != ST_RUN || selftest_ff[ST_MODE_LSB +: 2] == 2'b00)
        test_out_o <= 1'b0;
      else if (selftest_ff[ST_MODE_LSB + 1])
        test_out_o <= pin_s2_ff[1];
      else
        test_out_o <= !test_out_o;
    end
  end

  // Frame start once frame valid has held long enough in raw mode
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      fv_cnt_ff     <= 8'h00;
      fs_done_ff    <= 1'b0;
      frame_start_o <= 1'b0;
    end
    else if (!pin_s2_ff[2] || !raw_mode_i)
    begin
      fv_cnt_ff     <= 8'h00;
      fs_done_ff    <= 1'b0;
      frame_start_o <= 1'b0;
    end
    else
    begin
      frame_start_o <= !fs_done_ff && (fv_cnt_ff >= fv_min_ff);
      if (!fs_done_ff && (fv_cnt_ff >= fv_min_ff))
        fs_done_ff <= 1'b1;
      else if (fv_cnt_ff != 8'hff)
        fv_cnt_ff <= fv_cnt_ff + 8'h01;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      gpio_pd_en_o <= 8'h00;
    else
      gpio_pd_en_o <= ~gpio_oe_i & ~pd_dis_ff;
  end

  strap_latch u_idx_strap (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .strap_i   (idx_strap_i),
    .value_o   (idx_val),
    .done_o    (index_decode_done)
  );

  strap_latch u_mode_strap (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .strap_i   (mode_strap_i),
    .value_o   (mode_val),
    .done_o    (mode_done)
  );

  link_err_counter u_link_err (
    .sys_clk_i       (sys_clk_i),
    .rst_i           (rst_i),
    .err_i           (link_err_i),
    .filter_update_i (filter_update_i),
    .relock_i        (relock_i),
    .count_en_i      (link_ctl_ff[LE_EN_BIT]),
    .wait_ignore_i   (link_ctl_ff[LE_WAIT_BIT]),
    .threshold_i     (link_ctl_ff[3:0]),
    .locked_o        (rx_lock_o)
  );

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  property p_no_strobe_bad_sel;
    (ind_req_o.wr || ind_req_o.rd) |-> ind_target_valid(ind_req_o.sel);
  endproperty
  a_no_strobe_bad_sel: assert property (p_no_strobe_bad_sel) else $error("strobe to unmapped target");

  property p_auto_inc;
    (wr_data || rd_data) && auto_inc_ff && !wr_ofs |=> ind_req_o.offset == $past(ind_req_o.offset) + 8'h01;
  endproperty
  a_auto_inc: assert property (p_auto_inc) else $error("offset not advanced");

  property p_ofs_read;
    wr_ofs && read_pf_ff && sel_ok && !wr_ctl |=> ind_req_o.rd && ind_req_o.offset == $past(reg_wdata_i);
  endproperty
  a_ofs_read: assert property (p_ofs_read) else $error("no read strobe after offset write");

  sequence s_prefetch_read;
    rd_data && auto_inc_ff && read_pf_ff && sel_ok;
  endsequence
  property p_prefetch;
    s_prefetch_read |=> ind_req_o.rd ##1 (!ind_req_o.rd || $past(rd_data) || $past(wr_ofs));
  endproperty
  a_prefetch: assert property (p_prefetch) else $error("no prefetch after data read");

  property p_ind_write;
    wr_data && sel_ok |=> ind_req_o.wr && ind_req_o.wdata == $past(reg_wdata_i)
      && ind_req_o.wr_offset == $past(ind_req_o.offset);
  endproperty
  a_ind_write: assert property (p_ind_write) else $error("indirect write lost");

  property p_ind_read;
    rd_data |=> reg_rdata_o == ($past(sel_ok) ? $past(ind_rdata_i) : 8'h00);
  endproperty
  a_ind_read: assert property (p_ind_read) else $error("indirect read data wrong");

  property p_ctl_reserved;
    hit(reg_rd_i, reg_addr_i, ADDR_IND_CTL) |=> reg_rdata_o[7:6] == 2'b00;
  endproperty
  a_ctl_reserved: assert property (p_ctl_reserved) else $error("reserved bits not zero");

  sequence s_selftest_start;
    state_ff == ST_IDLE && st_enable ##1 state_ff == ST_LOAD;
  endsequence
  property p_remote_push;
    s_selftest_start |=> remote_o.wr && remote_o.addr == REMOTE_CLKSRC_OFS
      && remote_o.data[1:0] == $past(selftest_ff[ST_CLK_LSB +: 2]);
  endproperty
  a_remote_push: assert property (p_remote_push) else $error("clock source not pushed");

  property p_alt_toggle;
    state_ff == ST_RUN && selftest_ff[ST_MODE_LSB +: 2] == 2'b01 ##1
      state_ff == ST_RUN && selftest_ff[ST_MODE_LSB +: 2] == 2'b01 |=> test_out_o != $past(test_out_o);
  endproperty
  a_alt_toggle: assert property (p_alt_toggle) else $error("alternating output stuck");

  property p_pin_cfg;
    selftest_ff[ST_CFG_PIN_BIT] && !pin_s2_ff[0] && state_ff == ST_IDLE |=> state_ff == ST_IDLE;
  endproperty
  a_pin_cfg: assert property (p_pin_cfg) else $error("self-test started without pin");

  property p_frame_start;
    frame_start_o |-> $past(fv_cnt_ff) >= $past(fv_min_ff) && $past(pin_s2_ff[2]) && $past(raw_mode_i);
  endproperty
  a_frame_start: assert property (p_frame_start) else $error("frame start too early");

  property p_pulldown;
    !rst_i |=> gpio_pd_en_o == (~$past(gpio_oe_i) & ~$past(pd_dis_ff));
  endproperty
  a_pulldown: assert property (p_pulldown) else $error("pull-down enable wrong");

  property p_idx_latched;
    $rose(index_decode_done) |-> ##1 $stable(idx_val) ##1 $stable(idx_val);
  endproperty
  a_idx_latched: assert property (p_idx_latched) else $error("index value unstable");

  property p_mode_latched;
    mode_done |=> mode_done;
  endproperty
  a_mode_latched: assert property (p_mode_latched) else $error("mode done dropped");

endmodule // hub_shared_ctl

/* File: dv/ind_target_model.sv */
`timescale 1ns/1ps
module ind_target_model
  import hub_ctl_pkg::*;
(
  input  wire logic     sys_clk_i,
  input  wire logic     rst_i,
  input  wire ind_req_t req_i,
  output logic    [7:0] rdata_o,
  output logic    [7:0] wr_cnt_o,
  output logic    [7:0] rd_cnt_o
);
  logic [7:0] mem [5][256];

  initial
  begin
    foreach (mem[i, j]) mem[i][j] = 8'(j) ^ 8'h5a;
  end

  // Unmapped selects see a pattern that moves with the offset
  always_comb
  begin
    if (req_i.sel <= 4'h4) rdata_o = mem[req_i.sel][req_i.offset];
    else rdata_o = ~req_i.offset;
  end

  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      wr_cnt_o <= 8'h00;
      rd_cnt_o <= 8'h00;
    end
    else
    begin
      if (req_i.wr) wr_cnt_o <= wr_cnt_o + 8'h01;
      if (req_i.rd) rd_cnt_o <= rd_cnt_o + 8'h01;
      if (req_i.wr && req_i.sel <= 4'h4) mem[req_i.sel][req_i.wr_offset] <= req_i.wdata;
    end
  end
endmodule // ind_target_model

/* File: dv/hub_shared_ctl_tb.sv */
`timescale 1ns/1ps
module hub_shared_ctl_tb
  import hub_ctl_pkg::*;
;
  logic       sys_clk = 1'b0;
  logic       rst;
  logic [7:0] addr, wdata, rdata, ind_rdata, wcnt, rcnt, oe, pd, d, c0;
  logic       wr_s, rd_s, st_pin, st_data, st_act, tout, fupd, relock, lock, raw, fv, fs, t;
  logic [2:0] idx, mode;
  logic [3:0] lerr;
  ind_req_t   req;
  remote_wr_t rem;
  int         n_fail, cmp_count, n;
  logic [7:0] ra [6] = '{ADDR_IND_CTL, ADDR_IND_OFS, ADDR_SELFTEST, ADDR_LINK_ERR, ADDR_FV_MIN, 8'hb5};
  logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h08, 8'h03, 8'h80, 8'h00};

  always #5 sys_clk = ~sys_clk;

  hub_shared_ctl dut (.sys_clk_i(sys_clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .ind_req_o(req), .ind_rdata_i(ind_rdata),
    .selftest_pin_i(st_pin), .selftest_data_i(st_data), .selftest_active_o(st_act), .test_out_o(tout),
    .remote_o(rem), .idx_strap_i(idx), .mode_strap_i(mode), .link_err_i(lerr), .filter_update_i(fupd),
    .relock_i(relock), .rx_lock_o(lock), .raw_mode_i(raw), .frame_valid_i(fv), .frame_start_o(fs),
    .gpio_oe_i(oe), .gpio_pd_en_o(pd));

  ind_target_model mdl (.sys_clk_i(sys_clk), .rst_i(rst), .req_i(req), .rdata_o(ind_rdata),
    .wr_cnt_o(wcnt), .rd_cnt_o(rcnt));

  task automatic summarize();
    if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge sys_clk);
    wr_s <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge sys_clk);
    rd_s <= 1'b0;
    #1;
    v = rdata;
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: return rem.wr;
      1: return lock;
      2: return st_act;
      default: return fs;
    endcase
  endfunction

  task automatic poll(input string nm, input int k, input logic v);
    n = 0;
    while (sig(k) !== v && n < 40)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk(nm, {7'h0, sig(k)}, {7'h0, v});
    if (sig(k) !== v) summarize();
  endtask

  task automatic err(input int b);
    @(posedge sys_clk);
    lerr <= 4'h1 << b;
    @(posedge sys_clk);
    lerr <= 4'h0;
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic lock_up();
    @(posedge sys_clk);
    relock <= 1'b1;
    poll("lock_up", 1, 1'b1);
    @(posedge sys_clk);
    relock <= 1'b0;
  endtask

  initial
  begin
    repeat (100000) @(posedge sys_clk);
    n_fail++;
    summarize();
  end

  initial
  begin
    {rst, addr, wdata, wr_s, rd_s, st_pin, st_data, fupd, relock, raw, fv, oe, lerr} = '0;
    rst = 1'b1;
    idx = 3'h5;
    mode = 3'h3;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (ra[i])
    begin
      rd(ra[i], d);
      chk("reset value", d, rv[i]);
    end
    rd(ADDR_STRAP_STS, d);
    chk("strap done early", d & 8'h88, 8'h00);
    wr(ADDR_IND_CTL, 8'hff);
    rd(ADDR_IND_CTL, d);
    chk("ctl upper bits", d, 8'h3f);
    wr(ADDR_LINK_ERR, 8'hff);
    rd(ADDR_LINK_ERR, d);
    chk("link ctl", d, 8'h3f);
    wr(ADDR_IND_CTL, 8'h06);
    wr(ADDR_IND_OFS, 8'h10);
    wr(ADDR_IND_DATA, 8'haa);
    wr(ADDR_IND_DATA, 8'hbb);
    rd(ADDR_IND_OFS, d);
    chk("offset after writes", d, 8'h12);
    chk("target word 0", mdl.mem[1][8'h10], 8'haa);
    chk("target word 1", mdl.mem[1][8'h11], 8'hbb);
    wr(ADDR_IND_OFS, 8'h10);
    rd(ADDR_IND_DATA, d);
    chk("data read 0", d, 8'haa);
    rd(ADDR_IND_DATA, d);
    chk("data read 1", d, 8'hbb);
    for (int s = 0; s < 5; s++)
    begin
      wr(ADDR_IND_CTL, 8'(s << 2));
      wr(ADDR_IND_OFS, 8'hff);
      wr(ADDR_IND_DATA, 8'(8'h30 + s));
      @(posedge sys_clk);
      #1;
      chk("target select", mdl.mem[s][8'hff], 8'(8'h30 + s));
    end
    c0 = rcnt;
    wr(ADDR_IND_CTL, 8'h07);
    wr(ADDR_IND_OFS, 8'h40);
    @(posedge sys_clk);
    #1;
    chk("offset read strobe", rcnt, c0 + 8'h01);
    rd(ADDR_IND_DATA, d);
    chk("prefetched data", d, 8'h40 ^ 8'h5a);
    @(posedge sys_clk);
    #1;
    chk("prefetch strobe", rcnt, c0 + 8'h02);
    rd(ADDR_IND_OFS, d);
    chk("offset after read", d, 8'h41);
    foreach (ra[i])
    begin
      if (i < 2)
      begin
        c0 = wcnt;
        wr(ADDR_IND_CTL, i == 0 ? 8'h14 : 8'h3c);
        wr(ADDR_IND_DATA, 8'h55);
        rd(ADDR_IND_DATA, d);
        chk("unmapped read", d, 8'h00);
        chk("unmapped write", wcnt, c0);
      end
    end
    @(posedge sys_clk);
    st_data <= 1'b1;
    wr(ADDR_SELFTEST, 8'h05);
    poll("remote write", 0, 1'b1);
    chk("remote addr", rem.addr, REMOTE_CLKSRC_OFS);
    chk("remote data", rem.data, 8'h02);
    poll("selftest by reg", 2, 1'b1);
    chk("mode none", {7'h0, tout}, 8'h00);
    wr(ADDR_SELFTEST, 8'h45);
    repeat (3) @(posedge sys_clk);
    #1;
    t = tout;
    @(posedge sys_clk);
    #1;
    chk("mode alternate", {7'h0, tout}, {7'h0, ~t});
    wr(ADDR_SELFTEST, 8'h85);
    repeat (4) @(posedge sys_clk);
    #1;
    chk("mode data high", {7'h0, tout}, 8'h01);
    @(posedge sys_clk);
    st_data <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    chk("mode data low", {7'h0, tout}, 8'h00);
    wr(ADDR_SELFTEST, 8'h00);
    poll("selftest off", 2, 1'b0);
    @(posedge sys_clk);
    st_pin <= 1'b1;
    wr(ADDR_SELFTEST, 8'h08);
    poll("selftest by pin", 2, 1'b1);
    st_pin <= 1'b0;
    poll("selftest pin off", 2, 1'b0);
    wr(ADDR_LINK_ERR, 8'h00);
    lock_up();
    err(0);
    poll("drop first error", 1, 1'b0);
    wr(ADDR_LINK_ERR, 8'h13);
    lock_up();
    err(1);
    err(2);
    chk("lock below threshold", {7'h0, lock}, 8'h01);
    err(3);
    poll("drop at threshold", 1, 1'b0);
    wr(ADDR_LINK_ERR, 8'h20);
    lock_up();
    fupd <= 1'b1;
    err(0);
    chk("error in filter wait", {7'h0, lock}, 8'h01);
    repeat (60) @(posedge sys_clk);
    fupd <= 1'b0;
    err(1);
    poll("error after wait", 1, 1'b0);
    wr(ADDR_FV_MIN, 8'h05);
    @(posedge sys_clk);
    raw <= 1'b1;
    fv <= 1'b1;
    poll("frame start", 3, 1'b1);
    chk("frame start delay", {7'h0, n >= 5 && n <= 12}, 8'h01);
    @(posedge sys_clk);
    fv <= 1'b0;
    oe <= 8'h0f;
    wr(ADDR_GPIO_PD, 8'h81);
    repeat (2) @(posedge sys_clk);
    #1;
    chk("pull-down enables", pd, 8'h70);
    rd(ADDR_GPIO_PD, d);
    chk("pull-down ctl", d, 8'h81);
    wr(ADDR_STRAP_STS, 8'h00);
    rd(ADDR_STRAP_STS, d);
    chk("strap status", d, 8'hdb);
    summarize();
  end
endmodule // hub_shared_ctl_tb
